// ---- hdl/core_config_clock_interface.sv ----
// core configuration straps, clock-enabled data access engine and bus slave
`timescale 1ns/1ns
// How it works
// - endian select high gives big-endian byte order, low gives little-endian
// - feature disable high suppresses newer behaviour; low keeps it enabled
// - vector base is FFFF0000 with high-vector select high, else zero
// - every input but the asynchronous reset_n sampled on rising clock; outputs change on that edge
// - core advances only on edges with advance enable high, else holds
// - data address presented the cycle before its data memory cycle
// - receive-full status high while the receive buffer holds unread data
// - transmit-empty status high while transmit buffer can take a word
module core_config_clock_interface (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic endianSelect,
    input wire logic archFeatureDisable,
    input wire logic highVectorSelect,
    input wire logic coreAdvanceEnable,
    input wire logic dataAbortInput,
    input wire logic [31:0] memReadData,
    output logic [31:0] dataAddressBus,
    output logic [31:0] dataWriteData,
    output logic dataWrite,
    output logic dataRequest,
    output logic [31:0] exceptionVectorBase,
    output logic archFeatureActive,
    input wire logic dbgTxTake,
    output logic [31:0] dbgTxWord,
    input wire logic dbgRxWrite,
    input wire logic [31:0] dbgRxWord,
    output logic debugChannelRxFull,
    output logic debugChannelTxEmpty
);
    core_cfg_pkg::top_state_t r_reg;
    core_cfg_pkg::top_state_t r_next;
    logic accept;
    logic rdAccept;
    logic wrData;
    logic swTxWrite;
    logic swRxRead;
    logic busy;
    logic [31:0] rxWordW;
    logic rxFullW;
    logic txEmptyW;

    // address phase qualifiers; only whole-word transfers are honoured
    assign accept = hsel && htrans[1] && hready
        && hsize == core_cfg_pkg::SIZE_WORD;
    assign rdAccept = accept && !hwrite;
    assign wrData = r_reg.dpSel && r_reg.dpWrite;
    assign swTxWrite = wrData && r_reg.dpAddr == core_cfg_pkg::OFF_DCC_TX;
    assign swRxRead = rdAccept
        && haddr[7:0] == core_cfg_pkg::OFF_DCC_RX;
    assign busy = r_reg.state != core_cfg_pkg::ST_IDLE || r_reg.startPending;

    debug_channel u_dcc (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .swTxWrite(swTxWrite),
        .swTxData(hwdata),
        .swRxRead(swRxRead),
        .dbgTxTake(dbgTxTake),
        .dbgRxWrite(dbgRxWrite),
        .dbgRxData(dbgRxWord),
        .txWord(dbgTxWord),
        .rxWord(rxWordW),
        .rxFull(rxFullW),
        .txEmpty(txEmptyW)
    );

    // whole next state in one place
    always_comb begin
        logic [core_cfg_pkg::IRQ_W-1:0] ev;
        logic [core_cfg_pkg::IRQ_W-1:0] clr;
        ev = '0;
        clr = '0;
        r_next = r_reg;
        r_next.hreadyout = 1'b1;
        r_next.bigEnd = endianSelect;
        r_next.featDis = archFeatureDisable;
        r_next.hiVec = highVectorSelect;
        r_next.archFeatureActive = !archFeatureDisable;
        r_next.vectorBase = highVectorSelect ? core_cfg_pkg::VEC_HIGH
                                             : core_cfg_pkg::VEC_LOW;

        // read data is prepared in the address phase so it leaves a flop
        r_next.dpSel = accept;
        r_next.dpWrite = hwrite;
        r_next.dpAddr = haddr[7:0];
        r_next.hrdata = '0;
        if (rdAccept) begin
            case (haddr[7:0])
                core_cfg_pkg::OFF_ACC_CTRL: begin
                    r_next.hrdata[core_cfg_pkg::CTRL_GO] = busy;
                    r_next.hrdata[core_cfg_pkg::CTRL_WR] = r_reg.accWrite;
                end
                core_cfg_pkg::OFF_ACC_ADDR: r_next.hrdata = r_reg.accAddr;
                core_cfg_pkg::OFF_ACC_WDATA: r_next.hrdata = r_reg.accWdata;
                core_cfg_pkg::OFF_ACC_RDATA: r_next.hrdata = r_reg.accRdata;
                core_cfg_pkg::OFF_CONFIG: begin
                    r_next.hrdata[core_cfg_pkg::CFG_BIG] = r_reg.bigEnd;
                    r_next.hrdata[core_cfg_pkg::CFG_FEATDIS] = r_reg.featDis;
                    r_next.hrdata[core_cfg_pkg::CFG_HIVEC] = r_reg.hiVec;
                    r_next.hrdata[core_cfg_pkg::CFG_BUSY] = busy;
                    r_next.hrdata[core_cfg_pkg::CFG_ABORT] = r_reg.lastAbort;
                end
                core_cfg_pkg::OFF_VEC_BASE: r_next.hrdata = r_reg.vectorBase;
                core_cfg_pkg::OFF_IRQ_STATUS: begin
                    r_next.hrdata = 32'(r_reg.irqStatus);
                end
                core_cfg_pkg::OFF_IRQ_ENABLE: begin
                    r_next.hrdata = 32'(r_reg.irqEnable);
                end
                core_cfg_pkg::OFF_DCC_RX: r_next.hrdata = rxWordW;
                default: r_next.hrdata = '0;
            endcase
        end

        // data phase writes; access setup is locked while busy
        if (wrData) begin
            case (r_reg.dpAddr)
                core_cfg_pkg::OFF_ACC_CTRL: begin
                    if (!busy) begin
                        r_next.accWrite = hwdata[core_cfg_pkg::CTRL_WR];
                        r_next.startPending = hwdata[core_cfg_pkg::CTRL_GO];
                    end
                end
                core_cfg_pkg::OFF_ACC_ADDR: begin
                    if (!busy) begin
                        r_next.accAddr = hwdata;
                    end
                end
                core_cfg_pkg::OFF_ACC_WDATA: begin
                    if (!busy) begin
                        r_next.accWdata = hwdata;
                    end
                end
                core_cfg_pkg::OFF_IRQ_ENABLE: begin
                    r_next.irqEnable = hwdata[core_cfg_pkg::IRQ_W-1:0];
                end
                core_cfg_pkg::OFF_IRQ_CLEAR: begin
                    clr = hwdata[core_cfg_pkg::IRQ_W-1:0];
                end
                default: ;
            endcase
        end

        // engine moves only on enabled edges
        case (r_reg.state)
            core_cfg_pkg::ST_IDLE: begin
                if (coreAdvanceEnable && r_reg.startPending) begin
                    r_next.startPending = 1'b0;
                    // address put out ahead of memory cycle
                    r_next.dataAddressBus = r_reg.accAddr;
                    // alignment only when newer behaviour is off
                    if (r_reg.featDis) begin
                        r_next.dataAddressBus[1:0] = core_cfg_pkg::ALIGN_ZERO;
                    end
                    r_next.dataWrite = r_reg.accWrite;
                    r_next.dataWriteData = r_reg.bigEnd
                        ? core_cfg_pkg::swap_bytes(r_reg.accWdata)
                        : r_reg.accWdata;
                    r_next.dataRequest = 1'b1;
                    r_next.state = core_cfg_pkg::ST_ADDR;
                end
            end
            core_cfg_pkg::ST_ADDR: begin
                if (coreAdvanceEnable) begin
                    r_next.state = core_cfg_pkg::ST_DATA;
                end
            end
            core_cfg_pkg::ST_DATA: begin
                if (coreAdvanceEnable) begin
                    if (!r_reg.dataWrite) begin
                        r_next.accRdata = r_reg.bigEnd
                            ? core_cfg_pkg::swap_bytes(memReadData)
                            : memReadData;
                    end
                    // abort rides with the access data
                    r_next.lastAbort = dataAbortInput;
                    ev[core_cfg_pkg::IRQ_ABORT] = dataAbortInput;
                    ev[core_cfg_pkg::IRQ_DONE] = 1'b1;
                    r_next.dataRequest = 1'b0;
                    r_next.state = core_cfg_pkg::ST_IDLE;
                end
            end
            default: r_next.state = core_cfg_pkg::ST_IDLE;
        endcase

        // channel edges become events
        ev[core_cfg_pkg::IRQ_RXFULL] = rxFullW && !r_reg.rxFullPrev;
        ev[core_cfg_pkg::IRQ_TXEMPTY] = txEmptyW && !r_reg.txEmptyPrev;
        r_next.rxFullPrev = rxFullW;
        r_next.txEmptyPrev = txEmptyW;

        // sticky status: a new event beats a clear in the same cycle
        r_next.irqStatus = (r_reg.irqStatus & ~clr) | ev;
        r_next.irqOut = |(r_next.irqStatus & r_next.irqEnable);
    end

    // txEmptyPrev starts high so reset raises no spurious event
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '0;
            r_reg.state <= core_cfg_pkg::ST_IDLE;
            r_reg.hreadyout <= 1'b1;
            r_reg.txEmptyPrev <= 1'b1;
            r_reg.archFeatureActive <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flops, except hresp which is tied to zero
    assign hrdata = r_reg.hrdata;
    assign hreadyout = r_reg.hreadyout;
    assign hresp = 1'b0;
    assign irq = r_reg.irqOut;
    assign dataAddressBus = r_reg.dataAddressBus;
    assign dataWriteData = r_reg.dataWriteData;
    assign dataWrite = r_reg.dataWrite;
    assign dataRequest = r_reg.dataRequest;
    assign exceptionVectorBase = r_reg.vectorBase;
    assign archFeatureActive = r_reg.archFeatureActive;
    assign debugChannelRxFull = rxFullW;
    assign debugChannelTxEmpty = txEmptyW;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_endian_read;
        r_reg.state == core_cfg_pkg::ST_DATA && coreAdvanceEnable
            && !r_reg.dataWrite
        |=> r_reg.accRdata == ($past(r_reg.bigEnd)
            ? core_cfg_pkg::swap_bytes($past(memReadData))
            : $past(memReadData));
    endproperty
    a_endian_read: assert property (p_endian_read)
        else $error("read data byte order wrong");

    property p_feature;
        $past(reset_n) |-> archFeatureActive == !$past(archFeatureDisable);
    endproperty
    a_feature: assert property (p_feature)
        else $error("feature enable does not follow disable input");

    property p_vector;
        $past(reset_n) |-> exceptionVectorBase == ($past(highVectorSelect)
            ? core_cfg_pkg::VEC_HIGH : core_cfg_pkg::VEC_LOW);
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector base wrong");

    property p_abort_sample;
        r_reg.state == core_cfg_pkg::ST_DATA && coreAdvanceEnable
            && dataAbortInput
        |=> r_reg.irqStatus[core_cfg_pkg::IRQ_ABORT] && r_reg.lastAbort;
    endproperty
    a_abort_sample: assert property (p_abort_sample)
        else $error("abort not captured on rising edge");

    property p_hold;
        !coreAdvanceEnable |=> $stable(r_reg.state) && $stable(dataAddressBus)
            && $stable(dataRequest);
    endproperty
    a_hold: assert property (p_hold)
        else $error("core advanced with enable low");

    property p_addr_ahead;
        $rose(dataRequest) && coreAdvanceEnable
        |=> r_reg.state == core_cfg_pkg::ST_DATA
            && dataAddressBus == $past(dataAddressBus);
    endproperty
    a_addr_ahead: assert property (p_addr_ahead)
        else $error("address not held ahead of memory cycle");

    property p_irq;
        irq == |(r_reg.irqStatus & r_reg.irqEnable);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt level wrong");

    c_read: cover property ($rose(dataRequest) && !dataWrite
        ##[1:10] $fell(dataRequest));
    c_stall: cover property (dataRequest && !coreAdvanceEnable [*3]);
    c_abort: cover property (r_reg.state == core_cfg_pkg::ST_DATA
        && coreAdvanceEnable && dataAbortInput);
endmodule : core_config_clock_interface

// ---- hdl/debug_channel.sv ----
// debug communication channel: one-word transmit and receive buffers
`timescale 1ns/1ns
module debug_channel (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic swTxWrite,
    input wire logic [31:0] swTxData,
    input wire logic swRxRead,
    input wire logic dbgTxTake,
    input wire logic dbgRxWrite,
    input wire logic [31:0] dbgRxData,
    output logic [31:0] txWord,
    output logic [31:0] rxWord,
    output logic rxFull,
    output logic txEmpty
);
    core_cfg_pkg::dcc_state_t r_reg;
    core_cfg_pkg::dcc_state_t r_next;

    // a drain and a fill in one cycle hand the slot straight over
    always_comb begin
        r_next = r_reg;
        if (dbgTxTake) begin
            r_next.txEmpty = 1'b1;
        end
        if (swTxWrite && (r_reg.txEmpty || dbgTxTake)) begin
            r_next.txWord = swTxData;
            r_next.txEmpty = 1'b0;
        end
        if (swRxRead) begin
            r_next.rxFull = 1'b0;
        end
        if (dbgRxWrite && (!r_reg.rxFull || swRxRead)) begin
            r_next.rxWord = dbgRxData;
            r_next.rxFull = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '0;
            r_reg.txEmpty <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign txWord = r_reg.txWord;
    assign rxWord = r_reg.rxWord;
    assign rxFull = r_reg.rxFull;
    assign txEmpty = r_reg.txEmpty;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_rx_fill;
        dbgRxWrite && !rxFull |=> rxFull && rxWord == $past(dbgRxData);
    endproperty
    a_rx_fill: assert property (p_rx_fill)
        else $error("rx buffer did not report full after fill");

    property p_rx_drain;
        swRxRead && rxFull && !dbgRxWrite |=> !rxFull;
    endproperty
    a_rx_drain: assert property (p_rx_drain)
        else $error("rx buffer still full after read");

    property p_tx_fill;
        swTxWrite && txEmpty |=> !txEmpty ##0 txWord == $past(swTxData);
    endproperty
    a_tx_fill: assert property (p_tx_fill)
        else $error("tx buffer still empty after write");

    property p_tx_take;
        dbgTxTake && !txEmpty && !swTxWrite |=> txEmpty;
    endproperty
    a_tx_take: assert property (p_tx_take)
        else $error("tx buffer not empty after take");

    c_rx_round: cover property (dbgRxWrite ##[1:20] swRxRead && rxFull);
endmodule : debug_channel

// ---- inc/core_cfg_pkg.sv ----
// shared constants, types and helpers for the core configuration block
package core_cfg_pkg;

    // register byte offsets, decoded from haddr[7:0]
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_ACC_CTRL = 8'h00;
    localparam logic [7:0] OFF_ACC_ADDR = 8'h04;
    localparam logic [7:0] OFF_ACC_WDATA = 8'h08;
    localparam logic [7:0] OFF_ACC_RDATA = 8'h0C;
    localparam logic [7:0] OFF_CONFIG = 8'h10;
    localparam logic [7:0] OFF_VEC_BASE = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h1C;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;
    localparam logic [7:0] OFF_DCC_TX = 8'h24;
    localparam logic [7:0] OFF_DCC_RX = 8'h28;

    // access control fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_WR = 1;

    // config status fields
    localparam int CFG_BIG = 0;
    localparam int CFG_FEATDIS = 1;
    localparam int CFG_HIVEC = 2;
    localparam int CFG_BUSY = 3;
    localparam int CFG_ABORT = 4;

    // interrupt status layout
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_RXFULL = 2;
    localparam int IRQ_TXEMPTY = 3;

    // exception vector bases
    localparam logic [31:0] VEC_LOW = 32'h0000_0000;
    localparam logic [31:0] VEC_HIGH = 32'hFFFF_0000;

    // bus encodings
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [1:0] ALIGN_ZERO = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h4
    } access_state_t;

    typedef struct packed {
        access_state_t state;
        logic bigEnd;
        logic featDis;
        logic hiVec;
        logic archFeatureActive;
        logic [31:0] vectorBase;
        logic startPending;
        logic [31:0] accAddr;
        logic [31:0] accWdata;
        logic accWrite;
        logic [31:0] accRdata;
        logic lastAbort;
        logic [31:0] dataAddressBus;
        logic [31:0] dataWriteData;
        logic dataWrite;
        logic dataRequest;
        logic [IRQ_W-1:0] irqStatus;
        logic [IRQ_W-1:0] irqEnable;
        logic irqOut;
        logic rxFullPrev;
        logic txEmptyPrev;
        logic dpSel;
        logic dpWrite;
        logic [ADDR_W-1:0] dpAddr;
        logic [31:0] hrdata;
        logic hreadyout;
    } top_state_t;

    typedef struct packed {
        logic txEmpty;
        logic rxFull;
        logic [31:0] txWord;
        logic [31:0] rxWord;
    } dcc_state_t;

    // byte lane reversal between the two byte orders
    function automatic logic [31:0] swap_bytes(input logic [31:0] w);
        swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap_bytes

endpackage : core_cfg_pkg

// ---- verif/core_config_clock_interface_test.sv ----
// self-checking bench for the core configuration and data access block
`timescale 1ns/1ns
module core_config_clock_interface_test;
    logic ref_clk;
    logic reset_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic endianSelect;
    logic archFeatureDisable;
    logic highVectorSelect;
    logic coreAdvanceEnable;
    logic dataAbortInput;
    logic [31:0] memReadData;
    logic [31:0] dataAddressBus;
    logic [31:0] dataWriteData;
    logic dataWrite;
    logic dataRequest;
    logic [31:0] exceptionVectorBase;
    logic archFeatureActive;
    logic dbgTxTake;
    logic [31:0] dbgTxWord;
    logic dbgRxWrite;
    logic [31:0] dbgRxWord;
    logic debugChannelRxFull;
    logic debugChannelTxEmpty;
    logic [1:0] stallMode;
    logic [31:0] addrSeen;
    int numErrors;
    int checksDone;

    core_config_clock_interface core_config_clock_interface_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .endianSelect(endianSelect),
        .archFeatureDisable(archFeatureDisable),
        .highVectorSelect(highVectorSelect),
        .coreAdvanceEnable(coreAdvanceEnable),
        .dataAbortInput(dataAbortInput), .memReadData(memReadData),
        .dataAddressBus(dataAddressBus), .dataWriteData(dataWriteData),
        .dataWrite(dataWrite), .dataRequest(dataRequest),
        .exceptionVectorBase(exceptionVectorBase),
        .archFeatureActive(archFeatureActive), .dbgTxTake(dbgTxTake),
        .dbgTxWord(dbgTxWord), .dbgRxWrite(dbgRxWrite),
        .dbgRxWord(dbgRxWord), .debugChannelRxFull(debugChannelRxFull),
        .debugChannelTxEmpty(debugChannelTxEmpty)
    );

    mem_system_model mem_system_model_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .stallMode(stallMode),
        .dataAddressBus(dataAddressBus), .dataWriteData(dataWriteData),
        .dataWrite(dataWrite), .dataRequest(dataRequest),
        .coreAdvanceEnable(coreAdvanceEnable), .memReadData(memReadData),
        .dataAbortInput(dataAbortInput), .addrSeen(addrSeen)
    );

    // closing verdict, shared by the main sequence and the watchdog
    task automatic stopTest();
        $display("checks %0d errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stopTest

    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one single bus transfer; waits on ready, no fixed latency assumed
    task automatic busXfer(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : busXfer

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        busXfer(1'b1, a, d, unused);
    endtask : regWrite

    task automatic regCheck(input logic [7:0] a, input logic [31:0] exp,
            input string name);
        logic [31:0] v;
        busXfer(1'b0, a, 32'h0000_0000, v);
        check(name, v, exp);
    endtask : regCheck

    task automatic startAccess(input logic wr, input logic [31:0] a,
            input logic [31:0] wd);
        regWrite(core_cfg_pkg::OFF_ACC_ADDR, a);
        regWrite(core_cfg_pkg::OFF_ACC_WDATA, wd);
        regWrite(core_cfg_pkg::OFF_ACC_CTRL, ({31'h0, wr}
            << core_cfg_pkg::CTRL_WR) | (32'h1 << core_cfg_pkg::CTRL_GO));
    endtask : startAccess

    // poll busy with a bounded count; the watchdog covers a hang
    task automatic waitIdle();
        logic [31:0] v;
        for (int i = 0; i < 40; i++) begin
            busXfer(1'b0, core_cfg_pkg::OFF_CONFIG, 32'h0000_0000, v);
            if (v[core_cfg_pkg::CFG_BUSY] === 1'b0) break;
        end
    endtask : waitIdle

    function automatic logic [31:0] swapWord(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swapWord

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // watchdog: both passes need a few thousand cycles at most
    initial begin
        #200000;
        numErrors++;
        stopTest();
    end

    initial begin
        logic s;
        logic [31:0] exp;
        logic [2:0] st;
        {reset_n, hsel, hwrite, dbgTxTake, dbgRxWrite} = 5'h00;
        {endianSelect, archFeatureDisable, highVectorSelect} = 3'h0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hsize = core_cfg_pkg::SIZE_WORD;
        hwdata = 32'h0000_0000;
        dbgRxWord = 32'h0000_0000;
        stallMode = 2'h0;
        numErrors = 0;
        checksDone = 0;
        for (int pass = 0; pass < 2; pass++) begin
            s = pass[0];
            st = {3{s}};
            // straps only move while reset is held
            @(posedge ref_clk);
            reset_n <= 1'b0;
            stallMode <= 2'h0;
            {endianSelect, archFeatureDisable, highVectorSelect} <= st;
            repeat (20) @(posedge ref_clk);
            reset_n <= 1'b1;
            repeat (2) @(posedge ref_clk);
            exp = s ? core_cfg_pkg::VEC_HIGH : core_cfg_pkg::VEC_LOW;
            check("vector port", exceptionVectorBase, exp);
            regCheck(core_cfg_pkg::OFF_VEC_BASE, exp, "vector reg");
            check("feature", {31'h0, archFeatureActive}, {31'h0, !s});
            regCheck(core_cfg_pkg::OFF_CONFIG, {29'h0, st}, "config");
            regCheck(8'h40, 32'h0000_0000, "unmapped");
            check("hresp", {31'h0, hresp}, 32'h0000_0000);
            regWrite(core_cfg_pkg::OFF_IRQ_CLEAR, 32'h0000_000F);
            regWrite(core_cfg_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
            regCheck(core_cfg_pkg::OFF_IRQ_ENABLE, 32'h1, "irq enable");
            // write access to an unaligned address
            startAccess(1'b1, 32'h0000_0017, 32'h1122_3344);
            waitIdle();
            exp = s ? swapWord(32'h1122_3344) : 32'h1122_3344;
            check("write port", dataWriteData, exp);
            check("memory word", mem_system_model_i.mem[5], exp);
            exp = s ? 32'h0000_0014 : 32'h0000_0017;
            check("address port", dataAddressBus, exp);
            check("address cycle", addrSeen, exp);
            check("irq line", {31'h0, irq}, 32'h0000_0001);
            // read with alternating wait cycles
            stallMode <= 2'h1;
            startAccess(1'b0, 32'h0000_0008, 32'h0000_0000);
            waitIdle();
            exp = s ? swapWord(32'h1234_5602) : 32'h1234_5602;
            regCheck(core_cfg_pkg::OFF_ACC_RDATA, exp, "read data");
            // enable held low: the engine must not move
            stallMode <= 2'h2;
            regWrite(core_cfg_pkg::OFF_IRQ_CLEAR, 32'h0000_000F);
            startAccess(1'b0, 32'h0000_0030, 32'h0000_0000);
            repeat (10) @(posedge ref_clk);
            check("held request", {31'h0, dataRequest}, 32'h0);
            regCheck(core_cfg_pkg::OFF_CONFIG, {28'h0, 1'b1, st}, "busy");
            stallMode <= 2'h0;
            waitIdle();
            regCheck(core_cfg_pkg::OFF_CONFIG, {28'h1, 1'b0, st}, "abort");
            regCheck(core_cfg_pkg::OFF_IRQ_STATUS, 32'h3, "abort irq");
            // debug receive buffer filled, then drained by a read
            regWrite(core_cfg_pkg::OFF_IRQ_CLEAR, 32'h0000_000F);
            @(posedge ref_clk);
            dbgRxWord <= 32'hCAFE_0000 + pass;
            dbgRxWrite <= 1'b1;
            @(posedge ref_clk);
            dbgRxWrite <= 1'b0;
            @(posedge ref_clk);
            check("rx full", {31'h0, debugChannelRxFull}, 32'h1);
            regCheck(core_cfg_pkg::OFF_IRQ_STATUS, 32'h4, "rx irq");
            check("irq masked", {31'h0, irq}, 32'h0000_0000);
            regCheck(core_cfg_pkg::OFF_DCC_RX, 32'hCAFE_0000 + pass, "rx");
            check("rx drained", {31'h0, debugChannelRxFull}, 32'h0);
            // debug transmit buffer filled, then taken
            regWrite(core_cfg_pkg::OFF_DCC_TX, 32'hBEEF_0000 + pass);
            @(posedge ref_clk);
            check("tx full", {31'h0, debugChannelTxEmpty}, 32'h0);
            check("tx word", dbgTxWord, 32'hBEEF_0000 + pass);
            dbgTxTake <= 1'b1;
            @(posedge ref_clk);
            dbgTxTake <= 1'b0;
            @(posedge ref_clk);
            check("tx empty", {31'h0, debugChannelTxEmpty}, 32'h1);
            regCheck(core_cfg_pkg::OFF_IRQ_STATUS, 32'hC, "tx irq");
        end
        stopTest();
    end
endmodule : core_config_clock_interface_test

// ---- verif/mem_system_model.sv ----
// memory system model facing the core data port, with wait cycles
`timescale 1ns/1ns
module mem_system_model #(
    parameter logic [31:0] ABORT_ADDR = 32'h0000_0030
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [1:0] stallMode,
    input wire logic [31:0] dataAddressBus,
    input wire logic [31:0] dataWriteData,
    input wire logic dataWrite,
    input wire logic dataRequest,
    output logic coreAdvanceEnable,
    output logic [31:0] memReadData,
    output logic dataAbortInput,
    output logic [31:0] addrSeen
);
    logic [31:0] mem [16];
    logic inMem;
    logic [31:0] junk;

    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'h1234_5600 | i;
        end
    end

    // abort with data
    // outside the memory cycle the data bus shows changing junk
    assign memReadData = inMem ? mem[dataAddressBus[5:2]] : junk;
    assign dataAbortInput = inMem && dataRequest
        && (dataAddressBus == ABORT_ADDR);

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            coreAdvanceEnable <= 1'b0;
        end else begin
            case (stallMode)
                2'h0: coreAdvanceEnable <= 1'b1;
                2'h1: coreAdvanceEnable <= !coreAdvanceEnable;
                default: coreAdvanceEnable <= 1'b0;
            endcase
        end
    end

    // address only taken on enabled edges
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            inMem <= 1'b0;
            junk <= 32'h5A5A_0000;
        end else begin
            junk <= junk + 32'h0001_0003;
            if (coreAdvanceEnable && dataRequest) begin
                inMem <= !inMem;
                if (!inMem) begin
                    addrSeen <= dataAddressBus;
                end else if (dataWrite) begin
                    mem[dataAddressBus[5:2]] <= dataWriteData;
                end
            end
        end
    end
endmodule : mem_system_model
